// *** design/tef_status_top.sv ***
`timescale 1ns/1ps
// Event flags, live status and spare pin outputs of the touch controller
module tef_status_top
   import tef_pkg::*;
#(
   parameter int AVG_WIDTH = AVG_W
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Host register port, addressed by the serial interface
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Live conditions from the analog and conversion engines
   input wire logic motor_short_raw,
   input wire logic near_object_raw,
   input wire logic [AVG_WIDTH-1:0] near_average_raw,
   input wire logic near_enabled,
   input wire logic sampling_active,
   input wire tef_conv_kind_t conv_kind,
   input wire logic calibration_busy,
   input wire logic contact_now,
   input wire logic heat_warn_now,
   input wire logic heat_alarm_now,
   // Settings held in other register blocks
   input wire logic [7:0] event_enable_mask,
   input wire logic near_event_select,
   input wire logic contact_detect_mode,
   input wire logic heat_warn_edge_sel,
   input wire logic heat_alarm_edge_sel,
   input wire logic panel_wire_type,
   input wire logic [3:0] sensor_hookup,
   input wire logic [3:0] shield_hookup,
   // Results
   output logic calibration_request,
   output logic [AVG_WIDTH-1:0] near_average,
   output logic irq_req,
   // Spare pins
   output logic spare_pin_1_o,
   output logic spare_pin_1_oe,
   output logic spare_pin_2_o,
   output logic spare_pin_2_oe,
   output logic spare_pin_3_o,
   output logic spare_pin_3_oe
);
   // Sampled copies for edge detection
   logic motor_q, motor_d;
   logic near_q, near_d;
   logic calib_q, calib_d;
   logic samp_q, samp_d;
   logic contact_q, contact_d;
   logic warn_q, warn_d;
   logic alarm_q, alarm_d;
   tef_conv_kind_t kind_q, kind_d;
   // Held proximity state
   logic near_hold_q, near_hold_d;
   logic [AVG_WIDTH-1:0] avg_q, avg_d;
   // Host-owned state
   logic reboot_q, reboot_d;
   logic calib_req_q, calib_req_d;
   logic [7:0] spare_ctrl_q, spare_ctrl_d;
   logic [7:0] rdata_q, rdata_d;
   logic [7:0] pin_q, pin_d;
   // Flag plumbing
   logic [7:0] ev_now, ev_prev, ev_rise, ev_flags, status_now;
   logic flag_clr, status_rd;
   logic near_live;
   logic [2:0] sel_val;
   logic [2:0] sel_ok;
   logic [3:0] pin_sel [3];

   // Near status is zero when sensing is off; frozen while the pen is down.
   // Motor activity does not freeze it: the host gates scanning itself.
   // The held status also feeds the near and far events, so they freeze too.
   always_comb begin
      near_live = near_object_raw & near_enabled; // RULE11 RULE13
      near_hold_d = contact_now ? near_hold_q : near_live; // RULE12
      avg_d = contact_now ? avg_q : near_average_raw; // RULE12
   end

   // Held proximity registers; a reset reads as far with a zero average
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         near_hold_q <= 1'b0;
         avg_q <= '0;
      end else begin
         near_hold_q <= near_hold_d;
         avg_q <= avg_d;
      end
   end

   // Previous-cycle samples; conversion kind is remembered for its falling edge
   always_comb begin
      motor_d = motor_short_raw;
      near_d = near_hold_q;
      calib_d = calibration_busy | calib_req_q;
      samp_d = sampling_active;
      contact_d = contact_now;
      warn_d = heat_warn_now;
      alarm_d = heat_alarm_now;
      kind_d = sampling_active ? conv_kind : kind_q;
   end

   // Edge history resets low, the idle level of every source, so that
   // no false edge is seen as reset is released
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         motor_q <= 1'b0;
         near_q <= 1'b0;
         calib_q <= 1'b0;
         samp_q <= 1'b0;
         contact_q <= 1'b0;
         warn_q <= 1'b0;
         alarm_q <= 1'b0;
         kind_q <= TEF_CONV_TOUCH;
      end else begin
         motor_q <= motor_d;
         near_q <= near_d;
         calib_q <= calib_d;
         samp_q <= samp_d;
         contact_q <= contact_d;
         warn_q <= warn_d;
         alarm_q <= alarm_d;
         kind_q <= kind_d;
      end
   end

   // Per-source edge kind and source selection
   always_comb begin
      ev_now[BIT_MOTOR] = motor_short_raw; // RULE1
      ev_prev[BIT_MOTOR] = motor_q;
      ev_rise[BIT_MOTOR] = 1'b1;
      ev_now[BIT_REBOOT] = near_hold_q; // RULE2
      ev_prev[BIT_REBOOT] = near_q;
      ev_rise[BIT_REBOOT] = 1'b1;
      // Proximity conversion end is only a fall of activity after a near scan
      // Forcing both samples high after the other kind masks that fall out
      if (near_event_select) begin
         ev_now[BIT_NEAR] = sampling_active | (kind_q != TEF_CONV_NEAR); // RULE3
         ev_prev[BIT_NEAR] = samp_q | (kind_q != TEF_CONV_NEAR);
      end else begin
         ev_now[BIT_NEAR] = near_hold_q; // RULE3
         ev_prev[BIT_NEAR] = near_q;
      end
      ev_rise[BIT_NEAR] = 1'b0;
      ev_now[BIT_CALIB] = calibration_busy | calib_req_q; // RULE4
      ev_prev[BIT_CALIB] = calib_q;
      ev_rise[BIT_CALIB] = 1'b0;
      if (contact_detect_mode) begin
         ev_now[BIT_SAMPLING] = contact_now; // RULE5
         ev_prev[BIT_SAMPLING] = contact_q;
         ev_rise[BIT_SAMPLING] = 1'b1;
      end else begin
         ev_now[BIT_SAMPLING] = sampling_active | (kind_q != TEF_CONV_TOUCH); // RULE5
         ev_prev[BIT_SAMPLING] = samp_q | (kind_q != TEF_CONV_TOUCH);
         ev_rise[BIT_SAMPLING] = 1'b0;
      end
      ev_now[BIT_CONTACT] = contact_now; // RULE6
      ev_prev[BIT_CONTACT] = contact_q;
      ev_rise[BIT_CONTACT] = 1'b0;
      ev_now[BIT_WARN] = heat_warn_now; // RULE7
      ev_prev[BIT_WARN] = warn_q;
      ev_rise[BIT_WARN] = heat_warn_edge_sel;
      ev_now[BIT_ALARM] = heat_alarm_now; // RULE8
      ev_prev[BIT_ALARM] = alarm_q;
      ev_rise[BIT_ALARM] = heat_alarm_edge_sel;
   end

   // Read strobes decoded once; a flag read clears every flag at that edge,
   // but a source edge in the same cycle still lands in its flag
   assign flag_clr = reg_rd && (reg_addr == ADDR_EVENT_FLAGS); // RULE24
   assign status_rd = reg_rd && (reg_addr == ADDR_STATUS);

   // One sticky flag per event source
   // Set wins over a read clear in the same cycle
   for (genvar i = 0; i < 8; i++) begin : g_flag
      tef_edge_flag u_flag (
         .mclk(mclk),
         .nrst(nrst),
         .rise_sel(ev_rise[i]),
         .sig_now(ev_now[i]),
         .sig_prev(ev_prev[i]),
         .clr(flag_clr),
         .flag_q(ev_flags[i])
      );
   end

   // Interrupt request while any enabled flag stands
   // Kept combinational so masking a flag drops the request without delay
   assign irq_req = |(ev_flags & event_enable_mask); // RULE23 RULE24

   // Live status word; the reboot bit and the calibration request are latched, and the near bit is held
   always_comb begin
      status_now = 8'h00;
      status_now[BIT_MOTOR] = motor_short_raw; // RULE9
      status_now[BIT_REBOOT] = reboot_q; // RULE10
      status_now[BIT_NEAR] = near_hold_q; // RULE11
      status_now[BIT_CALIB] = calibration_busy | calib_req_q; // RULE14
      status_now[BIT_SAMPLING] = sampling_active; // RULE15
      status_now[BIT_CONTACT] = contact_now; // RULE16
      status_now[BIT_WARN] = heat_warn_now; // RULE17
      status_now[BIT_ALARM] = heat_alarm_now; // RULE17
   end

   // Host writes and read side effects
   always_comb begin
      reboot_d = reboot_q & ~status_rd; // RULE10
      // Request stands until the engine shows busy; a new write re-arms it
      calib_req_d = calib_req_q & ~calibration_busy;
      spare_ctrl_d = spare_ctrl_q;
      if (reg_wr && reg_addr == ADDR_STATUS && reg_wdata[BIT_CALIB]) begin
         calib_req_d = 1'b1; // RULE14
      end
      if (reg_wr && reg_addr == ADDR_SPARE_CTRL) begin
         spare_ctrl_d = reg_wdata & SPARE_CTRL_WMASK; // Bit 7 is reserved and reads 0
      end
   end

   // Read data follows the address every cycle; unmapped addresses read 0.
   // Registered, so data trails the address by one edge.
   always_comb begin
      unique case (reg_addr)
         ADDR_EVENT_FLAGS: rdata_d = ev_flags;
         ADDR_STATUS: rdata_d = status_now;
         ADDR_SPARE_CTRL: rdata_d = spare_ctrl_q;
         default: rdata_d = 8'h00;
      endcase
   end

   // Reboot flag comes up set: every reset counts as one having occurred
   // Request and control clear; read data reads zero until the first address
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         reboot_q <= 1'b1; // RULE10
         calib_req_q <= 1'b0;
         spare_ctrl_q <= SPARE_CTRL_RESET;
         rdata_q <= 8'h00;
      end else begin
         reboot_q <= reboot_d;
         calib_req_q <= calib_req_d;
         spare_ctrl_q <= spare_ctrl_d;
         rdata_q <= rdata_d;
      end
   end

   // Registered results to the host and the proximity engine
   assign reg_rdata = rdata_q;
   assign calibration_request = calib_req_q;
   assign near_average = avg_q;

   // Spare pin source selects: pin 1 from its own field. The select fields of
   // pins 2 and 3 live in a register this block does not hold, so they are
   // fixed to the lift-off and contact-or-sample flags.
   assign pin_sel[0] = spare_ctrl_q[3:0]; // RULE21
   assign pin_sel[1] = 4'(BIT_CONTACT);
   assign pin_sel[2] = 4'(BIT_SAMPLING);

   // One source mux per spare pin
   for (genvar p = 0; p < 3; p++) begin : g_pin
      tef_spare_mux u_mux (
         .sel(pin_sel[p]),
         .flags(ev_flags),
         .sampling(sampling_active),
         .pin_val(sel_val[p])
      );
   end

   // Enables overridden where the pin is busy as sensor or shield
   // A pin taken as sensor or shield never drives, whatever the host wrote
   always_comb begin
      sel_ok[0] = spare_ctrl_q[BIT_SP1_EN] && !panel_wire_type
                  && sensor_hookup != SENSOR_ON_SPARE1; // RULE18
      sel_ok[1] = spare_ctrl_q[BIT_SP2_EN]
                  && sensor_hookup != SENSOR_ON_SPARE2; // RULE19
      sel_ok[2] = spare_ctrl_q[BIT_SP3_EN] && !panel_wire_type
                  && shield_hookup != SHIELD_ON_SPARE3; // RULE20
      pin_d = 8'h00;
      pin_d[2:0] = sel_val;
      pin_d[5:3] = sel_ok;
   end

   // Pins registered so glitches from the mux never reach the board
   // The cost is one extra cycle from flag set to pin level
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         pin_q <= 8'h00;
      end else begin
         pin_q <= pin_d;
      end
   end

   // Level and enable per pin; the enable is high only while the pin drives
   assign spare_pin_1_o = pin_q[0];
   assign spare_pin_2_o = pin_q[1];
   assign spare_pin_3_o = pin_q[2];
   assign spare_pin_1_oe = pin_q[3];
   assign spare_pin_2_oe = pin_q[4];
   assign spare_pin_3_oe = pin_q[5];
endmodule

// *** design/tef_pkg.sv ***
// Functional notes
// RULE1 - Motor short rising edge sets event flag 7.
// RULE2 - Near-object rising edge sets event flag 6.
// RULE3 - Flag 5 from near-object fall or proximity conversion end, by select.
// RULE4 - Calibration-pending falling edge sets event flag 4.
// RULE5 - Flag 3: contact rise in detect mode, else touch conversion end.
// RULE6 - Contact falling edge sets event flag 2.
// RULE7 - Heat warning edge, polarity selectable, sets event flag 1.
// RULE8 - Heat alarm edge, polarity selectable, sets event flag 0.
// RULE9 - Status bit 7 shows live motor short, unlatched.
// RULE10 - Status bit 6 latches a reset, cleared by status read.
// RULE11 - Status bit 5 shows near object, zero when far or disabled.
// RULE12 - Near status and average held while the pen is down.
// RULE13 - Near status not frozen during motor run; host toggles scanning.
// RULE14 - Status bit 4 shows pending calibration; writing 1 requests one.
// RULE15 - Status bit 3 shows any conversion running.
// RULE16 - Status bit 2 shows live pen contact.
// RULE17 - Status bits 1 and 0 show live heat warning and alarm.
// RULE18 - Control bit 6 enables spare pin 1 unless panel type 1 or sensor 0001.
// RULE19 - Control bit 5 enables spare pin 2 unless sensor hookup 0010.
// RULE20 - Control bit 4 enables spare pin 3 unless panel type 1 or shield 0011.
// RULE21 - Bits 3:0 select spare pin 1 source; 0000 is event flag 0.
// RULE22 - Select codes 0000-0111 give event flags 0-7, 1011 gives status bit 3.
// RULE23 - Each event source has its own enable bit in the mask.
// RULE24 - Interrupt request while any enabled flag set; reading flags clears them.
package tef_pkg;
   localparam logic [7:0] ADDR_EVENT_FLAGS = 8'h23;
   localparam logic [7:0] ADDR_STATUS = 8'h24;
   localparam logic [7:0] ADDR_SPARE_CTRL = 8'h25;
   localparam logic [7:0] SPARE_CTRL_RESET = 8'h00;
   localparam logic [7:0] SPARE_CTRL_WMASK = 8'h7f;
   localparam int BIT_SP1_EN = 6;
   localparam int BIT_SP2_EN = 5;
   localparam int BIT_SP3_EN = 4;
   localparam int BIT_MOTOR = 7;
   localparam int BIT_REBOOT = 6;
   localparam int BIT_NEAR = 5;
   localparam int BIT_CALIB = 4;
   localparam int BIT_SAMPLING = 3;
   localparam int BIT_CONTACT = 2;
   localparam int BIT_WARN = 1;
   localparam int BIT_ALARM = 0;
   localparam logic [3:0] SEL_FLAG_MAX = 4'h7;
   localparam logic [3:0] SEL_SAMPLING = 4'hb;
   localparam logic [3:0] SENSOR_ON_SPARE1 = 4'h1;
   localparam logic [3:0] SENSOR_ON_SPARE2 = 4'h2;
   localparam logic [3:0] SHIELD_ON_SPARE3 = 4'h3;
   localparam logic [3:0] SENSOR_NONE = 4'h0;
   localparam int AVG_W = 16;
   // Source of a completed conversion, as reported by the conversion engine
   typedef enum logic {TEF_CONV_TOUCH = 1'b0, TEF_CONV_NEAR = 1'b1} tef_conv_kind_t;
endpackage

// *** design/tef_edge_flag.sv ***
`timescale 1ns/1ps
// One sticky event flag: set by a qualified edge, cleared on host read
module tef_edge_flag
   import tef_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Event and clear
   input wire logic rise_sel,
   input wire logic sig_now,
   input wire logic sig_prev,
   input wire logic clr,
   // Flag
   output logic flag_q
);
   logic flag_d;
   logic hit;

   // Set wins over a read clear in the same cycle, so no event is lost
   always_comb begin
      hit = rise_sel ? (sig_now & ~sig_prev) : (~sig_now & sig_prev);
      flag_d = hit | (flag_q & ~clr);
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         flag_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
      end
   end
endmodule

// *** design/tef_spare_mux.sv ***
`timescale 1ns/1ps
// Picks the internal signal that drives one spare pin
module tef_spare_mux
   import tef_pkg::*;
(
   // Sources
   input wire logic [3:0] sel,
   input wire logic [7:0] flags,
   input wire logic sampling,
   // Selected level
   output logic pin_val
);
   // Undefined codes drive low rather than some arbitrary flag
   always_comb begin
      if (sel <= SEL_FLAG_MAX) begin
         pin_val = flags[sel[2:0]]; // RULE21 RULE22
      end else if (sel == SEL_SAMPLING) begin
         pin_val = sampling; // RULE22
      end else begin
         pin_val = 1'b0;
      end
   end
endmodule

// *** verification/tef_status_sva.sv ***
`timescale 1ns/1ps
// Port-level checks of events, status and spare pin enables
module tef_status_sva
   import tef_pkg::*;
#(
   parameter int AVG_WIDTH = AVG_W
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   // Live conditions and settings
   input wire logic motor_short_raw,
   input wire logic sampling_active,
   input wire logic calibration_busy,
   input wire logic contact_now,
   input wire logic heat_warn_now,
   input wire logic heat_alarm_now,
   input wire logic [7:0] event_enable_mask,
   input wire logic heat_alarm_edge_sel,
   input wire logic panel_wire_type,
   input wire logic [3:0] sensor_hookup,
   // Results
   input wire logic calibration_request,
   input wire logic [AVG_WIDTH-1:0] near_average,
   input wire logic irq_req,
   input wire logic spare_pin_1_oe,
   input wire logic spare_pin_2_oe
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   // Status read followed by the same address on the next edge
   sequence s_stat_rd;
      reg_rd && reg_addr == ADDR_STATUS;
   endsequence
   sequence s_stat_again;
      s_stat_rd ##1 reg_addr == ADDR_STATUS;
   endsequence
   AST_MOTOR_EVT: assert property (
      $rose(motor_short_raw) |=> irq_req || !event_enable_mask[7])
      else $error("Motor short edge gave no request");
   AST_ALARM_EVT: assert property (
      $fell(heat_alarm_now) && !heat_alarm_edge_sel |=> irq_req || !event_enable_mask[0])
      else $error("Alarm fall gave no request");
   AST_MASK_OFF: assert property (
      event_enable_mask == 8'h00 |-> !irq_req)
      else $error("Request with every source masked");
   AST_STAT_LIVE: assert property (
      reg_addr == ADDR_STATUS |=> reg_rdata[7] == $past(motor_short_raw) && reg_rdata[3:0]
      == $past({sampling_active, contact_now, heat_warn_now, heat_alarm_now}))
      else $error("Status does not follow live inputs");
   AST_REBOOT_CLR: assert property (
      s_stat_again |=> !reg_rdata[BIT_REBOOT])
      else $error("Reboot bit survived a status read");
   AST_SP1_OFF: assert property (
      (panel_wire_type || sensor_hookup == SENSOR_ON_SPARE1) [*3] |-> !spare_pin_1_oe)
      else $error("Spare pin 1 driven while blocked");
   AST_SP2_OFF: assert property (
      (sensor_hookup == SENSOR_ON_SPARE2) [*3] |-> !spare_pin_2_oe)
      else $error("Spare pin 2 driven while blocked");
   AST_CAL_SET: assert property (
      reg_wr && reg_addr == ADDR_STATUS && reg_wdata[BIT_CALIB] && !calibration_busy
      |=> calibration_request)
      else $error("Calibration write not taken");
   AST_CAL_DROP: assert property (
      (calibration_busy && !reg_wr) [*2] |=> !calibration_request)
      else $error("Calibration request kept while busy");
   AST_AVG_HOLD: assert property (
      contact_now |=> $stable(near_average))
      else $error("Near average moved with pen down");
endmodule

bind tef_status_top tef_status_sva #(.AVG_WIDTH(AVG_WIDTH)) u_sva (.mclk, .nrst, .reg_addr,
   .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .motor_short_raw, .sampling_active,
   .calibration_busy, .contact_now, .heat_warn_now, .heat_alarm_now, .event_enable_mask,
   .heat_alarm_edge_sel, .panel_wire_type, .sensor_hookup, .calibration_request,
   .near_average, .irq_req, .spare_pin_1_oe, .spare_pin_2_oe);

// *** verification/tef_host_model.sv ***
`timescale 1ns/1ps
// Host side: register strobes launched from the falling edge, one cycle for a write and two for a read
module tef_host_model (
   // Clock
   input wire logic mclk,
   // Register port
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata
);
   // Idle bus shows the inverse of the last value, never a stale copy
   initial {reg_addr, reg_wr, reg_rd, reg_wdata} = '0;
   // Single write, taken at the next rising edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
      @(negedge mclk);
      {reg_addr, reg_wdata, reg_wr} = {~a, ~d, 1'b0};
   endtask
   // Two reads back to back; data trails its address by one edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d0, output logic [7:0] d1);
      @(negedge mclk);
      {reg_addr, reg_rd} = {a, 1'b1};
      @(negedge mclk);
      d0 = reg_rdata;
      @(negedge mclk);
      d1 = reg_rdata;
      {reg_addr, reg_rd} = {~a, 1'b0};
   endtask
endmodule

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
// Random live conditions against a reference model
module tb_top;
   import tef_pkg::*;
   logic mclk = 1'b0, nrst = 1'b0;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, event_enable_mask, mf, mctl, e;
   logic reg_wr, reg_rd, motor_short_raw, near_object_raw, near_enabled, sampling_active;
   logic calibration_busy, contact_now, heat_warn_now, heat_alarm_now, near_event_select;
   logic contact_detect_mode, heat_warn_edge_sel, heat_alarm_edge_sel, panel_wire_type;
   logic calibration_request, irq_req;
   logic [3:0] sensor_hookup, shield_hookup;
   logic [15:0] near_average_raw, near_average, rs, mavg;
   logic [5:0] pin;
   tef_conv_kind_t conv_kind;
   bit mreb, mcal, mne, mkind, ne, ce, pend, p_mot, p_cal, p_smp, p_con, p_w, p_a;
   int mismatches, n_tests;
   always #50 mclk = ~mclk;
   tef_status_top u_dut (.mclk, .nrst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
      .motor_short_raw, .near_object_raw, .near_average_raw, .near_enabled, .sampling_active,
      .conv_kind, .calibration_busy, .contact_now, .heat_warn_now, .heat_alarm_now,
      .event_enable_mask, .near_event_select, .contact_detect_mode, .heat_warn_edge_sel,
      .heat_alarm_edge_sel, .panel_wire_type, .sensor_hookup, .shield_hookup,
      .calibration_request, .near_average, .irq_req, .spare_pin_1_o(pin[0]),
      .spare_pin_1_oe(pin[1]), .spare_pin_2_o(pin[2]), .spare_pin_2_oe(pin[3]),
      .spare_pin_3_o(pin[4]), .spare_pin_3_oe(pin[5]));
   tef_host_model u_host (.mclk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata);
   // Reference model, stepped on the edge the design samples
   always @(posedge mclk) begin
      if (!nrst) begin
         {mf, mctl, mreb, mcal, mne, mkind} = {16'h0000, 4'h8};
         {p_mot, p_cal, p_smp, p_con, p_w, p_a} = '0;
      end else begin
         ne = contact_now ? mne : near_enabled & near_object_raw;
         ce = p_smp & !sampling_active;
         pend = calibration_busy | mcal;
         e = {motor_short_raw & !p_mot, ne & !mne, near_event_select ? ce & mkind : !ne & mne,
            !pend & p_cal, contact_detect_mode ? contact_now & !p_con : ce & !mkind,
            !contact_now & p_con, (heat_warn_now != p_w) && (heat_warn_now == heat_warn_edge_sel),
            (heat_alarm_now != p_a) && (heat_alarm_now == heat_alarm_edge_sel)};
         mf = (reg_rd && reg_addr == ADDR_EVENT_FLAGS) ? e : mf | e;
         if (reg_rd && reg_addr == ADDR_STATUS) mreb = 0;
         if (reg_wr && reg_addr == ADDR_SPARE_CTRL) mctl = reg_wdata & SPARE_CTRL_WMASK;
         if (reg_wr && reg_addr == ADDR_STATUS && reg_wdata[BIT_CALIB]) mcal = 1;
         else if (calibration_busy) mcal = 0;
         if (sampling_active) mkind = conv_kind;
         if (!contact_now) mavg = near_average_raw;
         {mne, p_mot, p_cal} = {ne, motor_short_raw, pend};
         {p_smp, p_con, p_w, p_a} = {sampling_active, contact_now, heat_warn_now, heat_alarm_now};
      end
   end
   function automatic logic [7:0] st();
      return {motor_short_raw, mreb, mne, calibration_busy | mcal, sampling_active, contact_now,
         heat_warn_now, heat_alarm_now};
   endfunction
   // Pins as {oe3, o3, oe2, o2, oe1, o1}; undriven levels are masked off by the caller
   function automatic logic [5:0] pins();
      return {mctl[4] && !panel_wire_type && shield_hookup != SHIELD_ON_SPARE3, mf[3],
         mctl[5] && sensor_hookup != SENSOR_ON_SPARE2, mf[2],
         mctl[6] && !panel_wire_type && sensor_hookup != SENSOR_ON_SPARE1,
         mctl[3:0] <= SEL_FLAG_MAX ? mf[mctl[2:0]] :
         (mctl[3:0] == SEL_SAMPLING) & sampling_active};
   endfunction
   function automatic logic [15:0] nx(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic ck(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Second read shows what the first one cleared
   task automatic rchk(input logic [7:0] a, input logic [7:0] e0, input logic [7:0] e1);
      logic [7:0] d0, d1;
      u_host.rd(a, d0, d1);
      ck(d0, e0);
      ck(d1, e1);
   endtask
   task automatic close_out();
      if (mismatches == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Hang guard
   initial begin
      repeat (100000) @(posedge mclk);
      mismatches++;
      close_out();
   end
   initial begin
      logic [5:0] ep, pm;
      {motor_short_raw, near_object_raw, near_enabled, sampling_active, calibration_busy,
         contact_now, heat_warn_now, heat_alarm_now, near_event_select, contact_detect_mode,
         heat_warn_edge_sel, heat_alarm_edge_sel, panel_wire_type, sensor_hookup, shield_hookup,
         near_average_raw} = '0;
      {event_enable_mask, rs, conv_kind} = {8'hff, 16'h4e7b, TEF_CONV_TOUCH};
      repeat (10) @(negedge mclk);
      nrst = 1'b1;
      rchk(ADDR_STATUS, st(), st() & 8'hbf);
      u_host.wr(ADDR_EVENT_FLAGS, 8'hff);
      rchk(ADDR_EVENT_FLAGS, 8'h00, 8'h00);
      rchk(8'h26, 8'h00, 8'h00);
      u_host.wr(ADDR_SPARE_CTRL, 8'hff);
      rchk(ADDR_SPARE_CTRL, 8'h7f, 8'h7f);
      u_host.wr(ADDR_STATUS, 8'h10);
      ck(calibration_request, 1'b1);
      calibration_busy = 1'b1;
      repeat (3) @(negedge mclk);
      ck(calibration_request, 1'b0);
      calibration_busy = 1'b0;
      repeat (3) @(negedge mclk);
      event_enable_mask = 8'h00;
      @(negedge mclk);
      ck(irq_req, 1'b0);
      event_enable_mask = 8'hff;
      rchk(ADDR_EVENT_FLAGS, 8'h10, 8'h00);
      // One change per step keeps edge order unambiguous
      for (int i = 0; i < 700; i++) begin
         rs = nx(rs);
         case (rs[3:0])
            4'h0: motor_short_raw = ~motor_short_raw;
            4'h1: near_object_raw = ~near_object_raw;
            4'h2: near_enabled = ~near_enabled;
            4'h3: sampling_active = ~sampling_active;
            4'h4: if (!sampling_active) conv_kind = tef_conv_kind_t'(rs[4]);
            4'h5: calibration_busy = ~calibration_busy;
            4'h6: contact_now = ~contact_now;
            4'h7: heat_warn_now = ~heat_warn_now;
            4'h8: heat_alarm_now = ~heat_alarm_now;
            4'h9: near_average_raw = rs;
            4'ha: {near_event_select, contact_detect_mode, heat_warn_edge_sel, heat_alarm_edge_sel,
               panel_wire_type} = rs[8:4];
            4'hb: {sensor_hookup, shield_hookup} = {2'b00, rs[5:4], 2'b00, rs[7:6]};
            4'hc: event_enable_mask = rs[15:8];
            4'hd: u_host.wr(ADDR_SPARE_CTRL, rs[15:8]);
            4'he: u_host.wr(ADDR_STATUS, rs[15:8] & (calibration_busy ? 8'hef : 8'hff));
            default: begin
               rchk(ADDR_EVENT_FLAGS, mf, 8'h00);
               rchk(ADDR_STATUS, st(), st());
               rchk(ADDR_SPARE_CTRL, mctl, mctl);
            end
         endcase
         repeat (3) @(negedge mclk);
         ck(irq_req, |(mf & event_enable_mask));
         ck(calibration_request, mcal);
         ck(near_average, mavg);
         ep = pins();
         pm = {1'b1, ep[5], 1'b1, ep[3], 1'b1, ep[1]};
         ck(pin & pm, ep & pm);
      end
      // Mid-run reset must latch the reboot bit again
      nrst = 1'b0;
      repeat (2) @(negedge mclk);
      nrst = 1'b1;
      @(negedge mclk);
      rchk(ADDR_STATUS, st(), st() & 8'hbf);
      close_out();
   end
endmodule
